/* dac_timer_pkg.sv */
/*
 * Package for the converter update timer and double buffer: register
 * offsets, field positions, reset values and widths.
 * Assumes an APB slave with 32-bit data and word-aligned byte addresses.
 */
package dac_timer_pkg;
    // Register byte offsets
    localparam logic [3:0] OUTPUT_VALUE_OFS = 4'h0;
    localparam logic [3:0] CONTROL_OFS = 4'h4;
    localparam logic [3:0] RELOAD_OFS = 4'h8;
    localparam logic [3:0] IRQ_STATUS_OFS = 4'hC;
    localparam logic [4:0] IRQ_MASK_OFS = 5'h10;
    localparam int ADDR_W = 5;

    // Control register fields
    localparam int CTRL_IRQ_BIT = 0;
    localparam int CTRL_DBL_BIT = 1;
    localparam int CTRL_CNT_BIT = 2;

    // Output value fields
    localparam int CODE_LSB = 6;
    localparam int CODE_W = 10;
    localparam int SPEED_BIT = 16;

    localparam int TIMER_W = 16;
    localparam logic [TIMER_W-1:0] RELOAD_RESET = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
endpackage : dac_timer_pkg

/* dac_down_counter.sv */
/*
 * Down-counter with reload for the update timer.
 * Assumes i_reload_value is stable register contents on the same clock.
 */
module dac_down_counter
    import dac_timer_pkg::*;
#(
    parameter int WIDTH = TIMER_W
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // Control
    input wire logic i_enable,
    input wire logic [WIDTH-1:0] i_reload_value,
    // Status
    output logic o_timeout
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic started;
        logic timeout;
    } cnt_s;

    cnt_s cnt_reg;
    cnt_s cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        cnt_next.timeout = 1'b0;
        if (i_enable) begin
            if (!cnt_reg.started) begin
                // First cycle after enable loads the programmed value
                cnt_next.started = 1'b1;
                cnt_next.count = i_reload_value;
            end else if (cnt_reg.count == '0) begin
                cnt_next.count = i_reload_value;
                cnt_next.timeout = 1'b1;
            end else begin
                cnt_next.count = cnt_reg.count - 1'b1;
            end
        end else begin
            // Count holds while disabled; restart reloads
            cnt_next.started = 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign o_timeout = cnt_reg.timeout;

    property p_disabled_quiet;
        @(posedge i_mclk) disable iff (!i_rstn)
        !i_enable |=> !cnt_reg.timeout;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("timeout while counter disabled");

    property p_decrement;
        @(posedge i_mclk) disable iff (!i_rstn)
        (i_enable && cnt_reg.started && cnt_reg.count != '0)
            |=> cnt_reg.count == $past(cnt_reg.count) - 1'b1;
    endproperty
    a_decrement: assert property (p_decrement)
        else $error("counter did not decrement by one");

    property p_reload;
        @(posedge i_mclk) disable iff (!i_rstn)
        (i_enable && cnt_reg.started && cnt_reg.count == '0)
            |=> cnt_reg.timeout && cnt_reg.count == $past(i_reload_value);
    endproperty
    a_reload: assert property (p_reload)
        else $error("counter did not reload at zero");

    c_timeout: cover property (@(posedge i_mclk) disable iff (!i_rstn) cnt_reg.timeout);
endmodule : dac_down_counter

/* dac_update_timer_double_buffer.sv */
/*
 * Control logic of a 10-bit converter: update timer, double buffer,
 * APB register slave and level interrupt.
 * Assumes APB master on i_mclk; the converter core samples o_code and
 * o_speed_sel directly.
 */
// The APB slave port and the register addresses were decided locally.
// Contract
// - Enabled counter decrements once per clock
// - Zero reloads counter and sets request flag
// - Control, reload readable; counter hidden
// - Double buffer needs both enable bits
// - Buffered write updates only the pre-buffer
// - Pre-buffer moves to live on timeout
// - Output value read returns live value
// - Unbuffered write updates live value immediately
// - Request flag bit 0, cleared by write
// - Double buffer bit 1, count bit 2
// - Reload value bits 15:0, reset zero
// - Code bits 15:6, speed bit 16
module dac_update_timer_double_buffer
    import dac_timer_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Converter core
    output logic [CODE_W-1:0] o_code,
    output logic o_speed_sel,
    // Interrupt
    output logic o_irq
);
    typedef struct packed {
        logic [CODE_W-1:0] live_code;
        logic live_speed;
        logic [CODE_W-1:0] pre_code;
        logic pre_speed;
        logic pre_pending;
        logic req_flag;
        logic double_buffer_enable;
        logic timeout_count_enable;
        logic [TIMER_W-1:0] timer_reload_value;
        logic irq_status;
        logic irq_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } regs_s;

    regs_s regs_reg;
    regs_s regs_next;
    logic timeout;
    logic dbl_active;
    logic access;
    logic wr;
    logic known;

    dac_down_counter #(
        .WIDTH(TIMER_W)
    ) u_counter (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_enable(regs_reg.timeout_count_enable),
        .i_reload_value(regs_reg.timer_reload_value),
        .o_timeout(timeout)
    );

    assign dbl_active = regs_reg.timeout_count_enable & regs_reg.double_buffer_enable;
    // Answer after one wait cycle: pready is registered and rises the cycle after penable
    assign access = i_psel & i_penable & ~regs_reg.pready;
    assign wr = access & i_pwrite;
    assign known = (i_paddr == ADDR_W'(OUTPUT_VALUE_OFS)) || (i_paddr == ADDR_W'(CONTROL_OFS))
        || (i_paddr == ADDR_W'(RELOAD_OFS)) || (i_paddr == ADDR_W'(IRQ_STATUS_OFS))
        || (i_paddr == IRQ_MASK_OFS);

    always_comb begin
        regs_next = regs_reg;
        regs_next.pready = access;
        regs_next.pslverr = access & ~known;
        regs_next.prdata = 32'h0000_0000;

        // Buffered value moves on the timeout cycle
        if (timeout && dbl_active && regs_reg.pre_pending) begin
            regs_next.live_code = regs_reg.pre_code;
            regs_next.live_speed = regs_reg.pre_speed;
            regs_next.pre_pending = 1'b0;
        end

        if (wr && i_paddr == ADDR_W'(OUTPUT_VALUE_OFS)) begin
            regs_next.req_flag = 1'b0;
            if (dbl_active) begin
                regs_next.pre_code = i_pwdata[CODE_LSB +: CODE_W];
                regs_next.pre_speed = i_pwdata[SPEED_BIT];
                regs_next.pre_pending = 1'b1;
            end else begin
                regs_next.live_code = i_pwdata[CODE_LSB +: CODE_W];
                regs_next.live_speed = i_pwdata[SPEED_BIT];
            end
        end
        if (wr && i_paddr == ADDR_W'(CONTROL_OFS)) begin
            // Request flag is hardware-owned; software writes ignored there
            regs_next.double_buffer_enable = i_pwdata[CTRL_DBL_BIT];
            regs_next.timeout_count_enable = i_pwdata[CTRL_CNT_BIT];
        end
        if (wr && i_paddr == ADDR_W'(RELOAD_OFS)) begin
            regs_next.timer_reload_value = i_pwdata[TIMER_W-1:0];
        end
        if (wr && i_paddr == ADDR_W'(IRQ_STATUS_OFS) && i_pwdata[0]) begin
            regs_next.irq_status = 1'b0;
        end
        if (wr && i_paddr == IRQ_MASK_OFS) begin
            regs_next.irq_mask = i_pwdata[0];
        end

        // Set beats clear in the same cycle
        if (timeout) begin
            regs_next.req_flag = 1'b1;
            regs_next.irq_status = 1'b1;
        end

        if (access && !i_pwrite) begin
            unique case (i_paddr)
                ADDR_W'(OUTPUT_VALUE_OFS): begin
                    regs_next.prdata[CODE_LSB +: CODE_W] = regs_reg.live_code;
                    regs_next.prdata[SPEED_BIT] = regs_reg.live_speed;
                end
                ADDR_W'(CONTROL_OFS): begin
                    regs_next.prdata[CTRL_IRQ_BIT] = regs_reg.req_flag;
                    regs_next.prdata[CTRL_DBL_BIT] = regs_reg.double_buffer_enable;
                    regs_next.prdata[CTRL_CNT_BIT] = regs_reg.timeout_count_enable;
                end
                ADDR_W'(RELOAD_OFS): begin
                    regs_next.prdata[TIMER_W-1:0] = regs_reg.timer_reload_value;
                end
                ADDR_W'(IRQ_STATUS_OFS): begin
                    regs_next.prdata[0] = regs_reg.irq_status;
                end
                IRQ_MASK_OFS: begin
                    regs_next.prdata[0] = regs_reg.irq_mask;
                end
                default: begin
                    regs_next.prdata = 32'h0000_0000;
                end
            endcase
        end

        regs_next.irq = regs_next.irq_status & regs_next.irq_mask;
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            regs_reg <= '0;
            regs_reg.live_code <= CODE_RESET;
            regs_reg.timer_reload_value <= RELOAD_RESET;
        end else begin
            regs_reg <= regs_next;
        end
    end

    assign o_prdata = regs_reg.prdata;
    assign o_pready = regs_reg.pready;
    assign o_pslverr = regs_reg.pslverr;
    assign o_code = regs_reg.live_code;
    assign o_speed_sel = regs_reg.live_speed;
    assign o_irq = regs_reg.irq;

    property p_buffered_write_holds;
        @(posedge i_mclk) disable iff (!i_rstn)
        (wr && i_paddr == ADDR_W'(OUTPUT_VALUE_OFS) && dbl_active && !timeout)
            |=> o_code == $past(o_code);
    endproperty
    a_buffered_write_holds: assert property (p_buffered_write_holds)
        else $error("buffered write changed the live value");

    property p_transfer;
        @(posedge i_mclk) disable iff (!i_rstn)
        (timeout && dbl_active && regs_reg.pre_pending)
            |=> o_code == $past(regs_reg.pre_code);
    endproperty
    a_transfer: assert property (p_transfer)
        else $error("pre-buffer not moved on timeout");

    property p_direct_write;
        @(posedge i_mclk) disable iff (!i_rstn)
        (wr && i_paddr == ADDR_W'(OUTPUT_VALUE_OFS) && !dbl_active)
            |=> o_code == $past(i_pwdata[15:6]);
    endproperty
    a_direct_write: assert property (p_direct_write)
        else $error("unbuffered write did not reach live value");

    property p_read_live;
        @(posedge i_mclk) disable iff (!i_rstn)
        (access && !i_pwrite && i_paddr == ADDR_W'(OUTPUT_VALUE_OFS))
            |=> o_prdata[15:6] == $past(o_code) && o_pready;
    endproperty
    a_read_live: assert property (p_read_live)
        else $error("read of output value not live");

    property p_flag_set;
        @(posedge i_mclk) disable iff (!i_rstn)
        timeout |=> regs_reg.req_flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("request flag not set on timeout");

    property p_flag_clear;
        @(posedge i_mclk) disable iff (!i_rstn)
        (wr && i_paddr == ADDR_W'(OUTPUT_VALUE_OFS) && !timeout) |=> !regs_reg.req_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("request flag not cleared by value write");

    property p_no_timeout_disabled;
        @(posedge i_mclk) disable iff (!i_rstn)
        !regs_reg.timeout_count_enable |=> !timeout;
    endproperty
    a_no_timeout_disabled: assert property (p_no_timeout_disabled)
        else $error("timeout with counting disabled");

    property p_period;
        @(posedge i_mclk) disable iff (!i_rstn)
        (timeout && regs_reg.timeout_count_enable && regs_reg.timer_reload_value == 16'h0003)
            ##1 (regs_reg.timeout_count_enable && regs_reg.timer_reload_value == 16'h0003)[*4]
            |-> timeout;
    endproperty
    a_period: assert property (p_period)
        else $error("timeout period wrong for reload 3");

    property p_read_control;
        @(posedge i_mclk) disable iff (!i_rstn)
        (access && !i_pwrite && i_paddr == ADDR_W'(CONTROL_OFS))
            |=> o_prdata == {29'h0, $past(regs_reg.timeout_count_enable),
                $past(regs_reg.double_buffer_enable), $past(regs_reg.req_flag)};
    endproperty
    a_read_control: assert property (p_read_control)
        else $error("control read does not match its bits");

    property p_read_reload;
        @(posedge i_mclk) disable iff (!i_rstn)
        (access && !i_pwrite && i_paddr == ADDR_W'(RELOAD_OFS))
            |=> o_prdata == {16'h0000, $past(regs_reg.timer_reload_value)};
    endproperty
    a_read_reload: assert property (p_read_reload)
        else $error("reload read does not match");

    property p_write_control;
        @(posedge i_mclk) disable iff (!i_rstn)
        (wr && i_paddr == ADDR_W'(CONTROL_OFS))
            |=> regs_reg.double_buffer_enable == $past(i_pwdata[CTRL_DBL_BIT])
                && regs_reg.timeout_count_enable == $past(i_pwdata[CTRL_CNT_BIT]);
    endproperty
    a_write_control: assert property (p_write_control)
        else $error("control write did not land");

    property p_write_reload;
        @(posedge i_mclk) disable iff (!i_rstn)
        (wr && i_paddr == ADDR_W'(RELOAD_OFS))
            |=> regs_reg.timer_reload_value == $past(i_pwdata[TIMER_W-1:0]);
    endproperty
    a_write_reload: assert property (p_write_reload)
        else $error("reload write did not land");

    property p_speed_direct;
        @(posedge i_mclk) disable iff (!i_rstn)
        (wr && i_paddr == ADDR_W'(OUTPUT_VALUE_OFS) && !dbl_active)
            |=> o_speed_sel == $past(i_pwdata[SPEED_BIT]);
    endproperty
    a_speed_direct: assert property (p_speed_direct)
        else $error("speed select not taken from bit 16");

    property p_read_reserved;
        @(posedge i_mclk) disable iff (!i_rstn)
        (access && !i_pwrite && i_paddr == ADDR_W'(OUTPUT_VALUE_OFS))
            |=> o_prdata[5:0] == 6'h00 && o_prdata[31:17] == 15'h0000;
    endproperty
    a_read_reserved: assert property (p_read_reserved)
        else $error("reserved output value bits read nonzero");

    // Double buffer bit alone must not hold a write back
    property p_single_enable_direct;
        @(posedge i_mclk) disable iff (!i_rstn)
        (wr && i_paddr == ADDR_W'(OUTPUT_VALUE_OFS) && regs_reg.double_buffer_enable
            && !regs_reg.timeout_count_enable)
            |=> o_code == $past(i_pwdata[15:6]);
    endproperty
    a_single_enable_direct: assert property (p_single_enable_direct)
        else $error("write buffered with counting disabled");

    property p_irq_on_timeout;
        @(posedge i_mclk) disable iff (!i_rstn)
        (timeout && regs_reg.irq_mask && !(wr && i_paddr == IRQ_MASK_OFS))
            |=> o_irq;
    endproperty
    a_irq_on_timeout: assert property (p_irq_on_timeout)
        else $error("unmasked timeout raised no interrupt");

    property p_status_set;
        @(posedge i_mclk) disable iff (!i_rstn)
        timeout |=> regs_reg.irq_status;
    endproperty
    a_status_set: assert property (p_status_set)
        else $error("status not set on timeout");

    property p_status_clear;
        @(posedge i_mclk) disable iff (!i_rstn)
        (wr && i_paddr == ADDR_W'(IRQ_STATUS_OFS) && i_pwdata[0] && !timeout)
            |=> !regs_reg.irq_status && !o_irq;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("status not cleared by writing one");

    property p_slverr_with_ready;
        @(posedge i_mclk) disable iff (!i_rstn)
        o_pslverr |-> o_pready;
    endproperty
    a_slverr_with_ready: assert property (p_slverr_with_ready)
        else $error("error response without ready");

    property p_pready_pulse;
        @(posedge i_mclk) disable iff (!i_rstn)
        o_pready |=> !o_pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse)
        else $error("ready held longer than one cycle");

    property p_idle_prdata;
        @(posedge i_mclk) disable iff (!i_rstn)
        !o_pready |-> o_prdata == 32'h0000_0000;
    endproperty
    a_idle_prdata: assert property (p_idle_prdata)
        else $error("read data driven outside a transfer");

    c_buffered: cover property (@(posedge i_mclk) disable iff (!i_rstn)
        timeout && dbl_active && regs_reg.pre_pending);
    c_direct: cover property (@(posedge i_mclk) disable iff (!i_rstn)
        wr && i_paddr == ADDR_W'(OUTPUT_VALUE_OFS) && !dbl_active);
    c_irq: cover property (@(posedge i_mclk) disable iff (!i_rstn) o_irq);
    c_refused: cover property (@(posedge i_mclk) disable iff (!i_rstn) o_pslverr);
endmodule : dac_update_timer_double_buffer

/* dac_update_timer_double_buffer_bench.sv */
/*
 * Self-checking bench for the converter update timer and double buffer.
 * Assumes the APB slave answers with pready after one wait cycle.
 */
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin num_errors++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module dac_update_timer_double_buffer_bench
    import dac_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [ADDR_W-1:0] A_OUT = ADDR_W'(OUTPUT_VALUE_OFS);
    localparam logic [ADDR_W-1:0] A_CTL = ADDR_W'(CONTROL_OFS);
    localparam logic [ADDR_W-1:0] A_RLD = ADDR_W'(RELOAD_OFS);
    localparam logic [ADDR_W-1:0] A_STS = ADDR_W'(IRQ_STATUS_OFS);
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [ADDR_W-1:0] i_paddr = '0;
    logic [31:0] i_pwdata = '0;
    logic [3:0] i_pstrb = 4'hF;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic [CODE_W-1:0] o_code;
    logic o_speed_sel;
    logic o_irq;
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int t0;
    int t1;
    logic [31:0] r;
    logic e;

    dac_update_timer_double_buffer dut_u (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .o_code(o_code), .o_speed_sel(o_speed_sel), .o_irq(o_irq));

    always #5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) cyc <= cyc + 1;

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= wd;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            $display("ERROR pready expected 1 seen none");
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic er;
        apb(1'b1, a, d, x, er);
        `CHK("write slverr", 1'b0, er)
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ex, input string nm);
        logic [31:0] x;
        logic er;
        apb(1'b0, a, 32'h0, x, er);
        `CHK(nm, {1'b0, ex}, {er, x})
    endtask : rd

    // Rising irq after a low spell; status cleared so the next one is seen
    task automatic wait_irq(output int t);
        int n;
        n = 0;
        while (o_irq === 1'b1 && n < 100) begin
            @(posedge i_mclk);
            n++;
        end
        while (o_irq !== 1'b1 && n < 300) begin
            @(posedge i_mclk);
            n++;
        end
        if (n >= 300) begin
            num_errors++;
            $display("ERROR irq expected 1 seen timeout");
        end
        t = cyc;
        wr(A_STS, 32'h1);
    endtask : wait_irq

    task results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge i_mclk);
        num_errors++;
        results();
    end

    initial begin
        repeat (6) @(posedge i_mclk);
        i_rstn <= 1'b1;
        rd(A_CTL, 32'h0, "control reset");
        rd(A_RLD, 32'h0, "reload reset");
        rd(A_OUT, 32'h0, "output reset");
        rd(A_STS, 32'h0, "status reset");
        rd(IRQ_MASK_OFS, 32'h0, "mask reset");
        apb(1'b0, 5'h14, 32'h0, r, e);
        `CHK("unmapped read", 33'h1_0000_0000, {e, r})
        apb(1'b1, 5'h1C, 32'h1, r, e);
        `CHK("unmapped write", 1'b1, e)
        wr(A_RLD, 32'hFFFF_FFFF);
        rd(A_RLD, 32'h0000_FFFF, "reload width");
        wr(A_OUT, 32'h0001_FFC0);
        @(posedge i_mclk);
        `CHK("live code", {1'b1, 10'h3FF}, {o_speed_sel, o_code})
        wr(A_OUT, 32'h0000_0A80);
        @(posedge i_mclk);
        `CHK("code field", {1'b0, 10'h02A}, {o_speed_sel, o_code})
        rd(A_OUT, 32'h0000_0A80, "output readback");
        wr(IRQ_MASK_OFS, 32'h1);
        // Period 21 leaves room for a few bus cycles between timeouts
        wr(A_RLD, 32'd20);
        wr(A_CTL, 32'h4);
        wait_irq(t0);
        wait_irq(t1);
        `CHK("timer period", 21, t1 - t0)
        rd(A_CTL, 32'h5, "flag set");
        wr(A_OUT, 32'h0000_0040);
        rd(A_CTL, 32'h4, "flag cleared");
        wr(A_CTL, 32'h6);
        wait_irq(t0);
        wr(A_OUT, 32'h0000_FFC0);
        @(posedge i_mclk);
        `CHK("prebuffer held", {1'b0, 10'h001}, {o_speed_sel, o_code})
        rd(A_OUT, 32'h0000_0040, "read live");
        wait_irq(t1);
        `CHK("prebuffer moved", {1'b0, 10'h3FF}, {o_speed_sel, o_code})
        `CHK("transfer period", 21, t1 - t0)
        rd(A_OUT, 32'h0000_FFC0, "live after move");
        wr(IRQ_MASK_OFS, 32'h0);
        repeat (25) @(posedge i_mclk);
        `CHK("masked irq", 1'b0, o_irq)
        rd(A_STS, 32'h1, "status sticky");
        wr(A_CTL, 32'h2);
        wr(A_STS, 32'h1);
        wr(IRQ_MASK_OFS, 32'h1);
        wr(A_OUT, 32'h0001_0000);
        @(posedge i_mclk);
        `CHK("direct write", {1'b1, 10'h000}, {o_speed_sel, o_code})
        repeat (50) @(posedge i_mclk);
        `CHK("idle irq", 1'b0, o_irq)
        rd(A_STS, 32'h0, "idle status");
        rd(A_CTL, 32'h2, "control bits");
        // Shortest period here exercises the reload-three period check
        wr(A_RLD, 32'h3);
        wr(A_CTL, 32'h4);
        repeat (12) @(posedge i_mclk);
        `CHK("short period irq", 1'b1, o_irq)
        rd(A_CTL, 32'h5, "short period flag");
        results();
    end
endmodule : dac_update_timer_double_buffer_bench
